// ===== core/vmd_vector_decode.sv
// Address decoder and interrupt vector fetch sequencer for the 8-bit core
`timescale 1ns/1ps
`include "vmd_map.svh"
`default_nettype none
// Contract
// - Decode the full 16-bit, 64K-byte address space for memory and registers.
// - Decode 128 bytes at the bottom as the hardware register area.
// - Map 1 Kbyte RAM, 60 bytes display RAM and 24 Kbytes program memory.
// - Stack accesses stay inside the 0100h to 01FFh page of RAM.
// - Reset vector sits at FFFE-FFFFh, software trap vector at FFFC-FFFDh.
// - Non-maskable pin interrupt vectors through FFFA-FFFBh.
// - Port A low external group vectors through FFF8-FFF9h.
// - Port A high external group vectors through FFF6-FFF7h.
// - Port B external group vectors through FFF4-FFF5h.
// - Port C external group vectors through FFF2-FFF3h.
// - Port D external group vectors through FFF0-FFF1h.
// - Each internal peripheral has its own pair from FFE0h; FFEC-FFEDh unused.
module vmd_vector_decode (
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire vmd_pkg::vmd_access_type   acc_in,
    output var  vmd_pkg::vmd_decode_type    dec_out,
    input  wire vmd_pkg::vmd_irq_req_type  irq_req_in,
    input  wire logic                      nmi_pin_in,
    output var  logic                      rd_req_out,
    output var  logic [15:0]               rd_addr_out,
    input  wire logic [7:0]                rd_data_in,
    input  wire logic                      rd_valid_in,
    output var  logic                      pc_load_out,
    output var  logic [15:0]               pc_value_out,
    output var  logic [3:0]                vec_slot_out,
    output var  logic                      vec_busy_out
);
    import vmd_pkg::*;

    // Decode stage
    vmd_region_type    region_w;
    vmd_decode_type    dec_r;
    vmd_decode_type    dec_nxt;
    // Interrupt capture
    logic              nmi_sync_w;
    logic              nmi_prev_r;
    logic              nmi_prev_nxt;
    logic              nmi_pend_r;
    logic              nmi_pend_nxt;
    logic              boot_r;
    logic              boot_nxt;
    logic              nmi_edge_w;
    logic              nmi_take_w;
    logic              boot_take_w;
    logic [15:0]       req_w;
    logic              pick_valid_w;
    logic [3:0]        pick_slot_w;
    // Vector fetch sequencer
    vmd_vec_state_type state_r;
    vmd_vec_state_type state_nxt;
    logic [3:0]        slot_r;
    logic [3:0]        slot_nxt;
    logic [7:0]        hi_r;
    logic [7:0]        hi_nxt;
    logic              rd_req_r;
    logic              rd_req_nxt;
    logic [15:0]       rd_addr_r;
    logic [15:0]       rd_addr_nxt;
    logic              pc_load_r;
    logic              pc_load_nxt;
    logic [15:0]       pc_val_r;
    logic [15:0]       pc_val_nxt;
    logic              busy_r;
    logic              busy_nxt;

    // Region lookup for the presented address
    vmd_region_decode u_region (
        .addr_in    (acc_in.addr),
        .region_out (region_w)
    );

    // Pin input brought into the core clock domain
    vmd_sync2 u_nmi_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (nmi_pin_in),
        .q_out  (nmi_sync_w)
    );

    // Decode: one registered answer per access, stack accesses folded into page 01h
    always_comb begin
        dec_nxt            = dec_r;
        dec_nxt.valid      = acc_in.valid;
        if (acc_in.valid) begin
            dec_nxt.region     = region_w;
            dec_nxt.phys_addr  = acc_in.addr;
            dec_nxt.stack_wrap = 1'b0;
            if (acc_in.stack) begin
                dec_nxt.region     = RGN_RAM;
                dec_nxt.phys_addr  = {`VMD_STACK_PAGE, acc_in.addr[7:0]};
                dec_nxt.stack_wrap = (acc_in.addr[15:8] != `VMD_STACK_PAGE);
            end
        end
    end

    // Decode register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    // Request vector, bit index equals vector slot, so higher address wins
    assign req_w = {boot_r,
                    irq_req_in.trap,
                    nmi_pend_r,
                    irq_req_in.ext_irq_group_porta_low,
                    irq_req_in.ext_irq_group_porta_high,
                    irq_req_in.ext_irq_group_portb,
                    irq_req_in.ext_irq_group_portc,
                    irq_req_in.ext_irq_group_portd,
                    irq_req_in.main_clock_controller,
                    1'b0,
                    irq_req_in.can,
                    irq_req_in.spi,
                    irq_req_in.timer_a,
                    irq_req_in.timer_b,
                    irq_req_in.async_serial_unit,
                    irq_req_in.i2c};

    // Priority pick of the highest pending slot
    always_comb begin
        pick_valid_w = 1'b0;
        pick_slot_w  = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (req_w[i]) begin
                pick_valid_w = 1'b1;
                pick_slot_w  = 4'(i);
            end
        end
    end

    // Slots taken from the pending latches when a fetch starts
    assign nmi_take_w  = (state_r == VS_IDLE) && pick_valid_w && (pick_slot_w == `VMD_SLOT_NMI);
    assign boot_take_w = (state_r == VS_IDLE) && pick_valid_w && (pick_slot_w == `VMD_SLOT_RESET);
    assign nmi_edge_w  = nmi_sync_w & ~nmi_prev_r;

    // Pending latches: a new edge beats a take in the same cycle
    always_comb begin
        nmi_prev_nxt = nmi_sync_w;
        nmi_pend_nxt = (nmi_pend_r & ~nmi_take_w) | nmi_edge_w;
        boot_nxt     = boot_r & ~boot_take_w;
    end

    // Pending latch registers; reset fetch is armed by reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            nmi_prev_r <= 1'b0;
            nmi_pend_r <= 1'b0;
            boot_r     <= 1'b1;
        end else begin
            nmi_prev_r <= nmi_prev_nxt;
            nmi_pend_r <= nmi_pend_nxt;
            boot_r     <= boot_nxt;
        end
    end

    // Fetch sequencer: read high byte, then low byte, then load the counter
    always_comb begin
        state_nxt   = state_r;
        slot_nxt    = slot_r;
        hi_nxt      = hi_r;
        rd_req_nxt  = rd_req_r;
        rd_addr_nxt = rd_addr_r;
        pc_load_nxt = 1'b0;
        pc_val_nxt  = pc_val_r;
        busy_nxt    = busy_r;
        case (state_r)
            VS_IDLE: begin
                if (pick_valid_w) begin
                    slot_nxt    = pick_slot_w;
                    rd_req_nxt  = 1'b1;
                    rd_addr_nxt = `VMD_VEC_BASE + {11'h000, pick_slot_w, 1'b0};
                    busy_nxt    = 1'b1;
                    state_nxt   = VS_HIGH;
                end
            end
            VS_HIGH: begin
                if (rd_valid_in) begin
                    hi_nxt      = rd_data_in;
                    rd_addr_nxt = 16'(rd_addr_r + 16'h0001);
                    state_nxt   = VS_LOW;
                end
            end
            VS_LOW: begin
                if (rd_valid_in) begin
                    rd_req_nxt  = 1'b0;
                    pc_val_nxt  = {hi_r, rd_data_in};
                    pc_load_nxt = 1'b1;
                    state_nxt   = VS_LOAD;
                end
            end
            VS_LOAD: begin
                busy_nxt  = 1'b0;
                state_nxt = VS_IDLE;
            end
            default: begin
                rd_req_nxt = 1'b0;
                busy_nxt   = 1'b0;
                state_nxt  = VS_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r   <= VS_IDLE;
            slot_r    <= 4'h0;
            hi_r      <= 8'h00;
            rd_req_r  <= 1'b0;
            rd_addr_r <= 16'h0000;
            pc_load_r <= 1'b0;
            pc_val_r  <= 16'h0000;
            busy_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            slot_r    <= slot_nxt;
            hi_r      <= hi_nxt;
            rd_req_r  <= rd_req_nxt;
            rd_addr_r <= rd_addr_nxt;
            pc_load_r <= pc_load_nxt;
            pc_val_r  <= pc_val_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // Outputs straight from registers
    assign dec_out      = dec_r;
    assign rd_req_out   = rd_req_r;
    assign rd_addr_out  = rd_addr_r;
    assign pc_load_out  = pc_load_r;
    assign pc_value_out = pc_val_r;
    assign vec_slot_out = slot_r;
    assign vec_busy_out = busy_r;

    // Every access gets its answer on the next edge
    decode_answer_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_in.valid |=> dec_out.valid && dec_out.phys_addr[7:0] == $past(acc_in.addr[7:0]))
        else $error("decode answer missing or wrong");

    // Low 128 bytes decode as registers
    reg_area_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_in.valid && !acc_in.stack && acc_in.addr < 16'h0080 |=> dec_out.region == RGN_REGS)
        else $error("register area not decoded");

    // RAM, display RAM and program memory boundaries
    mem_regions_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_in.valid && !acc_in.stack |=>
        ((dec_out.region == RGN_RAM) == (dec_out.phys_addr inside {[16'h0080:16'h047F]})) &&
        ((dec_out.region == RGN_DISP) == (dec_out.phys_addr inside {[16'h0800:16'h083B]})) &&
        ((dec_out.region == RGN_PROG) == (dec_out.phys_addr inside {[16'hA000:16'hFFDF]})))
        else $error("memory region boundary wrong");

    // Stack accesses land in page 01h and flag a wrap
    stack_page_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_in.valid && acc_in.stack |=> dec_out.phys_addr[15:8] == 8'h01 &&
        dec_out.stack_wrap == ($past(acc_in.addr[15:8]) != 8'h01))
        else $error("stack access left the stack page");

    // First fetch after reset reads the reset vector
    reset_fetch_a: assert property (@(posedge clk_in)
        $fell(rst_in) |-> ##1 rd_req_out && rd_addr_out == 16'hFFFE && vec_slot_out == 4'hF)
        else $error("reset vector not fetched first");

    // Non-maskable pin interrupt pair
    cpu_vectors_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_req_out && state_r == VS_HIGH && vec_slot_out == 4'hD |-> rd_addr_out == 16'hFFFA)
        else $error("non-maskable vector address wrong");

    // Software trap fetch starts at its own pair
    trap_vector_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_req_out && state_r == VS_HIGH && vec_slot_out == `VMD_SLOT_TRAP |-> rd_addr_out == 16'hFFFC)
        else $error("trap vector address wrong");

    // Synced NMI edge becomes pending one edge later
    nmi_pend_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(nmi_sync_w) |=> nmi_pend_r)
        else $error("pin interrupt edge lost");

    // Every first read of a fetch points at slot pair in the table
    ext_vectors_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(busy_r) |-> rd_addr_out == {12'hFFE, vec_slot_out[3:0]} + {12'h000, vec_slot_out})
        else $error("vector pair address wrong");

    // Unused pair never read
    unused_pair_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_req_out |-> rd_addr_out[15:1] != 15'h7FF6)
        else $error("unused vector pair read");

    // Counter load joins the two bytes, high first
    pc_join_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == VS_LOW && rd_valid_in |=> pc_load_out && pc_value_out ==
        {$past(hi_r), $past(rd_data_in)} ##1 !pc_load_out && !vec_busy_out)
        else $error("program counter load wrong");

endmodule // vmd_vector_decode
`default_nettype wire

// ===== core/vmd_map.svh
// Address map and vector slot constants for the vector map and address decode block
`ifndef VMD_MAP_SVH
`define VMD_MAP_SVH

// Hardware register area, 128 bytes
`define VMD_REG_BASE     16'h0000
`define VMD_REG_LAST     16'h007F
// General RAM, 1 Kbyte, holding the stack page
`define VMD_RAM_BASE     16'h0080
`define VMD_RAM_LAST     16'h047F
`define VMD_STACK_PAGE   8'h01
// Display RAM, 60 bytes
`define VMD_DISP_BASE    16'h0800
`define VMD_DISP_LAST    16'h083B
// User program memory, 24 Kbytes, vector table at its top
`define VMD_PROG_BASE    16'hA000
`define VMD_PROG_LAST    16'hFFFF
`define VMD_VEC_BASE     16'hFFE0

// Vector slots: handler pair sits at VMD_VEC_BASE + 2 * slot
`define VMD_SLOT_I2C     4'h0
`define VMD_SLOT_SERIAL  4'h1
`define VMD_SLOT_TIMB    4'h2
`define VMD_SLOT_TIMA    4'h3
`define VMD_SLOT_SPI     4'h4
`define VMD_SLOT_CAN     4'h5
`define VMD_SLOT_UNUSED  4'h6
`define VMD_SLOT_CLKCTL  4'h7
`define VMD_SLOT_PORTD   4'h8
`define VMD_SLOT_PORTC   4'h9
`define VMD_SLOT_PORTB   4'hA
`define VMD_SLOT_PORTAH  4'hB
`define VMD_SLOT_PORTAL  4'hC
`define VMD_SLOT_NMI     4'hD
`define VMD_SLOT_TRAP    4'hE
`define VMD_SLOT_RESET   4'hF

`endif

// ===== core/vmd_pkg.sv
// Types shared by the vector map and address decode block
package vmd_pkg;

    // Address regions seen by the decoder
    typedef enum logic [2:0] {
        RGN_NONE, RGN_REGS, RGN_RAM, RGN_DISP, RGN_PROG, RGN_VECT
    } vmd_region_type;

    // Vector fetch sequencer states
    typedef enum logic [1:0] {
        VS_IDLE, VS_HIGH, VS_LOW, VS_LOAD
    } vmd_vec_state_type;

    // One access presented by the core
    typedef struct packed {
        logic        valid;
        logic        stack;
        logic [15:0] addr;
    } vmd_access_type;

    // Registered decode answer
    typedef struct packed {
        logic           valid;
        vmd_region_type region;
        logic           stack_wrap;
        logic [15:0]    phys_addr;
    } vmd_decode_type;

    // Interrupt requests held by the core and its peripherals
    typedef struct packed {
        logic trap;
        logic ext_irq_group_porta_low;
        logic ext_irq_group_porta_high;
        logic ext_irq_group_portb;
        logic ext_irq_group_portc;
        logic ext_irq_group_portd;
        logic main_clock_controller;
        logic can;
        logic spi;
        logic timer_a;
        logic timer_b;
        logic async_serial_unit;
        logic i2c;
    } vmd_irq_req_type;

endpackage

// ===== core/vmd_sync2.sv
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module vmd_sync2 (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic d_in,
    output var  logic q_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = d_in;
        sync_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_out = sync_r;
endmodule // vmd_sync2
`default_nettype wire

// ===== core/vmd_region_decode.sv
// Combinational mapping of a 16-bit address onto its region
`timescale 1ns/1ps
`include "vmd_map.svh"
`default_nettype none
module vmd_region_decode (
    input  wire logic [15:0]            addr_in,
    output var  vmd_pkg::vmd_region_type region_out
);
    import vmd_pkg::*;

    // Vector table wins over the rest of program memory
    always_comb begin
        region_out = RGN_NONE;
        if (addr_in <= `VMD_REG_LAST) begin
            region_out = RGN_REGS;
        end else if (addr_in >= `VMD_RAM_BASE && addr_in <= `VMD_RAM_LAST) begin
            region_out = RGN_RAM;
        end else if (addr_in >= `VMD_DISP_BASE && addr_in <= `VMD_DISP_LAST) begin
            region_out = RGN_DISP;
        end else if (addr_in >= `VMD_VEC_BASE) begin
            region_out = RGN_VECT;
        end else if (addr_in >= `VMD_PROG_BASE) begin
            region_out = RGN_PROG;
        end
    end
endmodule // vmd_region_decode
`default_nettype wire

// ===== bench/vmd_core_mem_model.sv
// Behavioural model of the core memory that answers vector byte reads
`timescale 1ns/1ps
`default_nettype none
module vmd_core_mem_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        rd_req_in,
    input  wire logic [15:0] rd_addr_in,
    input  wire logic [1:0]  delay_in,
    output var  logic [7:0]  rd_data_out,
    output var  logic        rd_valid_out
);
    logic [1:0] wait_r;

    // One-cycle answer after delay_in waits; idle data toggles so it never looks valid
    always @(posedge clk_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= 8'h00;
            wait_r       <= 2'h0;
        end else if (rd_valid_out) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= ~rd_data_out;
            wait_r       <= 2'h0;
        end else if (rd_req_in && wait_r >= delay_in) begin
            rd_valid_out <= 1'b1;
            rd_data_out  <= rd_addr_in[7:0] ^ 8'h96;
        end else begin
            wait_r      <= wait_r + {1'b0, rd_req_in};
            rd_data_out <= ~rd_data_out;
        end
    end
endmodule // vmd_core_mem_model
`default_nettype wire

// ===== bench/vector_map_and_address_decode_tb_top.sv
// Self-checking testbench for the vector map and address decode block
`timescale 1ns/1ps
`default_nettype none
module vector_map_and_address_decode_tb_top;
    import vmd_pkg::*;
    logic            clk_in = 1'b0;
    logic            rst_in = 1'b1;
    vmd_access_type  acc = '0;
    vmd_decode_type  dec;
    vmd_irq_req_type irq = '0;
    logic            nmi = 1'b0;
    logic            rd_req, rd_valid, pc_load, busy;
    logic [15:0]     rd_addr, pc_value, first_addr;
    logic [7:0]      rd_data;
    logic [3:0]      slot;
    logic [1:0]      rd_delay = 2'h0;
    logic [19:0]     dq[$];
    logic [19:0]     vq[$];
    logic [19:0]     e;
    logic [31:0]     r;
    logic [15:0]     bounds[14] = '{16'h0000, 16'h007F, 16'h0080, 16'h047F, 16'h0480, 16'h07FF, 16'h0800,
                                   16'h083B, 16'h083C, 16'h9FFF, 16'hA000, 16'hFFDF, 16'hFFE0, 16'hFFFF};
    int              errors = 0;
    int              comparisons = 0;
    integer          seed = 32'h3156;

    vmd_vector_decode vmd_vector_decode_i (
        .clk_in(clk_in), .rst_in(rst_in), .acc_in(acc), .dec_out(dec), .irq_req_in(irq),
        .nmi_pin_in(nmi), .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
        .rd_valid_in(rd_valid), .pc_load_out(pc_load), .pc_value_out(pc_value),
        .vec_slot_out(slot), .vec_busy_out(busy)
    );

    vmd_core_mem_model vmd_core_mem_model_i (
        .clk_in(clk_in), .rst_in(rst_in), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
        .delay_in(rd_delay), .rd_data_out(rd_data), .rd_valid_out(rd_valid)
    );

    // 100 MHz clock
    always #5 clk_in = ~clk_in;

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Expected region of a plain access
    function automatic vmd_region_type region_of(input logic [15:0] a);
        if (a <= 16'h007F) return RGN_REGS;
        if (a <= 16'h047F) return RGN_RAM;
        if (a >= 16'h0800 && a <= 16'h083B) return RGN_DISP;
        if (a >= 16'hA000 && a <= 16'hFFDF) return RGN_PROG;
        if (a >= 16'hFFE0) return RGN_VECT;
        return RGN_NONE;
    endfunction

    // Slot served by request bit b of the request struct
    function automatic logic [3:0] slot_of(input int b);
        return (b < 6) ? 4'(b) : (b < 12) ? 4'(b + 1) : 4'hE;
    endfunction

    // Note the slot and the handler that the memory model holds for it
    function automatic void push_vec(input logic [3:0] s);
        logic [15:0] base;
        base = 16'hFFE0 + {11'h000, s, 1'b0};
        vq.push_back({s, base[7:0] ^ 8'h96, base[7:0] ^ 8'h97});
    endfunction

    // One decode access per cycle, expectation noted first
    task automatic access(input logic [15:0] a, input logic s);
        acc.valid = 1'b1;
        acc.stack = s;
        acc.addr  = a;
        if (s) dq.push_back({RGN_RAM, a[15:8] != 8'h01, 8'h01, a[7:0]});
        else dq.push_back({region_of(a), 1'b0, a});
        @(negedge clk_in);
    endtask

    // Raise requests, note expected order, drop each one once its handler is loaded
    task automatic serve(input logic [12:0] mask);
        int n;
        // Let one edge pass so a request just dropped is never raised again in the same step
        @(negedge clk_in);
        r = $random(seed);
        rd_delay = r[1:0];
        irq = mask;
        for (int b = 12; b >= 0; b--) if (mask[b]) push_vec(slot_of(b));
        n = 0;
        while (irq != '0 && n < 400) begin
            @(negedge clk_in);
            n++;
            if (pc_load === 1'b1) for (int b = 0; b < 13; b++) if (slot_of(b) == slot) irq[b] = 1'b0;
        end
        if (n >= 400) check("fetch_done", 32'h0, 32'h1);
    endtask

    // Result monitor: takes the oldest note whenever a result appears
    always @(negedge clk_in) begin
        if (rd_valid === 1'b1 && rd_addr[0] === 1'b0) first_addr = rd_addr;
        if (dec.valid === 1'b1) begin
            e = (dq.size() > 0) ? dq.pop_front() : 20'hFFFFF;
            check("decode", {dec.region, dec.stack_wrap, dec.phys_addr}, e);
        end
        if (pc_load === 1'b1) begin
            e = (vq.size() > 0) ? vq.pop_front() : 20'hFFFFF;
            check("vector", {slot, pc_value}, e);
            check("vector_addr", first_addr, 16'hFFE0 + {e[19:16], 1'b0});
            check("load_state", {busy, rd_req}, 32'h2);
        end
    end

    // Main sequence
    initial begin
        push_vec(4'hF);
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        foreach (bounds[i]) access(bounds[i], 1'b0);
        foreach (bounds[i]) access(bounds[i] ^ 16'h0100, 1'b1);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            access(r[15:0], r[16]);
        end
        acc.valid = 1'b0;
        for (int b = 0; b < 13; b++) serve(13'h0001 << b);
        // Pin interrupt first, then a lower group waits behind it
        push_vec(4'hD);
        nmi = 1'b1;
        repeat (6) @(negedge clk_in);
        nmi = 1'b0;
        serve(13'h0800);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            serve(r[12:0]);
        end
        // Reset again mid-run: outputs clear, then the reset vector is fetched once more
        push_vec(4'hF);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        check("reset_idle", {pc_load, busy, rd_req, dec.valid}, 32'h0);
        rst_in = 1'b0;
        @(negedge clk_in);
        check("reset_fetch", {busy, rd_req, slot, rd_addr}, {1'b1, 1'b1, 4'hF, 16'hFFFE});
        repeat (20) @(negedge clk_in);
        check("queues_empty", dq.size() + vq.size(), 32'h0);
        final_report();
    end

    // Watchdog against a hang
    initial begin
        #300us;
        errors++;
        final_report();
    end
endmodule // vector_map_and_address_decode_tb_top
`default_nettype wire
